// File: hdl/period_match_timer.sv
// What this block does
// - counts on instruction clock, system clock over four
// - prescaler divides by one, four or sixteen
// - equal count and period gives match output
// - match zeroes counter on next counting tick, steps postscaler
// - counter and period readable and writable
// - reset zeroes counter, period to all ones
// - counter or control write clears both scalers
// - postscaler output sets latched match flag
// - sixteen postscale ratios one to sixteen
// - interrupt only when flag and enable set
// - unscaled match goes to pwm units
// - match selectable as spi shift clock
// - sleep stops counting, registers hold
`timescale 1ns/100ps
`include "period_match_timer_defines.svh"

module period_match_timer (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // processor state
  input  wire logic        i_sleep,
  // axi write address
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  // axi write data
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  // axi write response
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // axi read address
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  // axi read data
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // timer outputs
  output period_match_timer_pkg::timer_out_t o_tmr,
  output logic             o_irq
);

  // ==========================================
  // state
  logic [7:0]  count_r;          // period_counter
  logic [7:0]  period_r;         // period_match_value
  period_match_timer_pkg::control_t ctl_r; // counter_control
  logic [1:0]  iclk_r;           // system to instruction clock divider
  logic [3:0]  pre_r;            // prescaler count
  logic [3:0]  post_r;           // postscaler count
  logic        flag_r;           // match_event_flag
  logic        enable_r;         // match_event_enable
  logic        spi_sel_r;        // route match to spi shift clock
  logic        sleep_s1_r;       // sleep synchroniser stage one
  logic        sleep_s2_r;       // sleep synchroniser stage two
  logic        zero_pend_r;      // match seen, zero on next tick
  logic        match_r;          // registered match output
  logic        spi_clk_r;        // shift clock toggle
  logic        irq_r;            // registered interrupt
  // bus state
  period_match_timer_pkg::wr_state_t wr_state_r;
  logic        aw_have_r;        // address latched
  logic        w_have_r;         // data latched
  logic [7:0]  aw_addr_r;        // latched write address
  logic [31:0] w_data_r;         // latched write data
  logic [3:0]  w_strb_r;         // latched strobes
  logic [1:0]  bresp_r;          // write response code
  logic        rvalid_r;         // read data valid
  logic [31:0] rdata_r;          // read data
  logic [1:0]  rresp_r;          // read response code
  logic        awready_r;        // write address ready
  logic        wready_r;         // write data ready
  logic        bvalid_r;         // write response valid
  logic        arready_r;        // read address ready

  // ==========================================
  // combinational terms
  logic        wr_fire;          // write executes this cycle
  logic        wr_count;         // write to counter lane 0
  logic        wr_period;        // write to period lane 0
  logic        wr_ctl;           // write to control lane 0
  logic        iclk_tick;        // one instruction clock
  logic [3:0]  pre_tc;           // prescaler terminal count
  logic        cnt_tick;         // one counting clock
  logic        is_match;         // comparator equal
  logic        post_event;       // postscaler terminal reached
  logic        scaler_clr;       // clears both scalers

  // address decode shared by read and write
  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == `OFF_COUNT_VALUE) || (a == `OFF_PERIOD_VALUE) ||
                 (a == `OFF_CONTROL) || (a == `OFF_IRQ_STATUS) ||
                 (a == `OFF_IRQ_MASK) || (a == `OFF_OUT_SELECT);
  endfunction

  // prescale selection to terminal count
  always_comb begin
    case (ctl_r.in_div)
      2'b00:   pre_tc = `PRE_TC_DIV1;
      2'b01:   pre_tc = `PRE_TC_DIV4;
      default: pre_tc = `PRE_TC_DIV16;
    endcase
  end

  // write strobes and timing ticks
  always_comb begin
    wr_fire    = aw_have_r && w_have_r && (wr_state_r == period_match_timer_pkg::WR_IDLE);
    wr_count   = wr_fire && w_strb_r[0] && (aw_addr_r == `OFF_COUNT_VALUE);
    wr_period  = wr_fire && w_strb_r[0] && (aw_addr_r == `OFF_PERIOD_VALUE);
    wr_ctl     = wr_fire && w_strb_r[0] && (aw_addr_r == `OFF_CONTROL);
    iclk_tick  = (iclk_r == `ICLK_DIV_TC);
    cnt_tick   = iclk_tick && (pre_r == pre_tc) && ctl_r.run && !sleep_s2_r;
    is_match   = (count_r == period_r);
    post_event = cnt_tick && is_match && !zero_pend_r && (post_r == ctl_r.out_div);
    scaler_clr = wr_count || wr_ctl;
  end

  // ==========================================
  // sleep synchroniser
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sleep_s1_r <= 1'b0;
      sleep_s2_r <= 1'b0;
    end else begin
      // the first stage is read by nothing but the second
      sleep_s1_r <= i_sleep;
      sleep_s2_r <= sleep_s1_r;
    end
  end

  // instruction clock divider, frozen in sleep
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      iclk_r <= 2'h0;
    end else if (!sleep_s2_r) begin
      iclk_r <= iclk_r + 2'h1;
    end
  end

  // prescaler
  always_ff @(posedge i_clk) begin
    if (i_rst || scaler_clr) begin
      pre_r <= 4'h0;
    end else if (iclk_tick && ctl_r.run && !sleep_s2_r) begin
      pre_r <= (pre_r == pre_tc) ? 4'h0 : pre_r + 4'h1;
    end
  end

  // ==========================================
  // period counter, zeroed on tick after a match
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_r     <= `RST_COUNT_VALUE;
      zero_pend_r <= 1'b0;
    end else if (wr_count) begin
      // a software write wins over counting
      count_r     <= w_data_r[7:0];
      zero_pend_r <= 1'b0;
    end else if (cnt_tick) begin
      if (zero_pend_r) begin
        // zero one counting tick after the match
        count_r     <= 8'h00;
        zero_pend_r <= 1'b0;
      end else if (is_match) begin
        zero_pend_r <= 1'b1;
      end else begin
        count_r <= count_r + 8'h01;
      end
    end
  end

  // postscaler advanced by each match
  always_ff @(posedge i_clk) begin
    if (i_rst || scaler_clr) begin
      post_r <= 4'h0;
    end else if (cnt_tick && is_match && !zero_pend_r) begin
      post_r <= post_event ? 4'h0 : post_r + 4'h1;
    end
  end

  // match outputs and interrupt
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      match_r   <= 1'b0;
      spi_clk_r <= 1'b0;
      irq_r     <= 1'b0;
    end else begin
      match_r   <= cnt_tick && is_match && !zero_pend_r;
      // toggle only while routed to the shift clock
      if (cnt_tick && is_match && !zero_pend_r && spi_sel_r) begin
        spi_clk_r <= !spi_clk_r;
      end
      irq_r     <= flag_r && enable_r;
    end
  end

  // ==========================================
  // software registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      period_r  <= `RST_PERIOD_VALUE;
      ctl_r     <= `RST_CONTROL;
      enable_r  <= 1'b0;
      spi_sel_r <= 1'b0;
    end else begin
      if (wr_period) begin
        period_r <= w_data_r[7:0];
      end
      if (wr_ctl) begin
        ctl_r <= w_data_r[6:0];
      end
      if (wr_fire && w_strb_r[0] && (aw_addr_r == `OFF_IRQ_MASK)) begin
        enable_r <= w_data_r[0];
      end
      if (wr_fire && w_strb_r[0] && (aw_addr_r == `OFF_OUT_SELECT)) begin
        spi_sel_r <= w_data_r[0];
      end
    end
  end

  // sticky flag, set wins over write-one clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flag_r <= 1'b0;
    end else if (post_event) begin
      flag_r <= 1'b1;
    end else if (wr_fire && w_strb_r[0] && w_data_r[0] &&
                 (aw_addr_r == `OFF_IRQ_STATUS)) begin
      // write one to clear, lost when an event lands the same cycle
      flag_r <= 1'b0;
    end
  end

  // ==========================================
  // axi write channels, address and data in either order
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_have_r  <= 1'b0;
      w_have_r   <= 1'b0;
      aw_addr_r  <= 8'h00;
      w_data_r   <= 32'h0000_0000;
      w_strb_r   <= 4'h0;
      bresp_r    <= `RESP_OKAY;
      wr_state_r <= period_match_timer_pkg::WR_IDLE;
      awready_r  <= 1'b1;
      wready_r   <= 1'b1;
      bvalid_r   <= 1'b0;
    end else begin
      // take the address, then refuse another until the response
      if (i_awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        awready_r <= 1'b0;
        aw_addr_r <= {i_awaddr[7:2], 2'b00};
      end
      // take the data, before or after the address
      if (i_wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        wready_r <= 1'b0;
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
      end
      case (wr_state_r)
        period_match_timer_pkg::WR_IDLE: begin
          if (wr_fire) begin
            bresp_r    <= known_addr(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
            bvalid_r   <= 1'b1;
            wr_state_r <= period_match_timer_pkg::WR_RESP;
          end
        end
        period_match_timer_pkg::WR_RESP: begin
          if (i_bready) begin
            aw_have_r  <= 1'b0;
            w_have_r   <= 1'b0;
            awready_r  <= 1'b1;
            wready_r   <= 1'b1;
            bvalid_r   <= 1'b0;
            wr_state_r <= period_match_timer_pkg::WR_IDLE;
          end
        end
        default: begin
          bvalid_r   <= 1'b0;
          wr_state_r <= period_match_timer_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // axi read channel, one cycle to data
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `RESP_OKAY;
      arready_r <= 1'b1;
    end else if (rvalid_r) begin
      // answer stands until the master takes it
      if (i_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end else if (i_arvalid) begin
      // one read at a time, data on the next cycle
      rvalid_r  <= 1'b1;
      arready_r <= 1'b0;
      rresp_r  <= known_addr({i_araddr[7:2], 2'b00}) ? `RESP_OKAY : `RESP_SLVERR;
      case ({i_araddr[7:2], 2'b00})
        `OFF_COUNT_VALUE:  rdata_r <= {24'h00_0000, count_r};
        `OFF_PERIOD_VALUE: rdata_r <= {24'h00_0000, period_r};
        `OFF_CONTROL:      rdata_r <= {25'h000_0000, ctl_r};
        `OFF_IRQ_STATUS:   rdata_r <= {31'h0000_0000, flag_r};
        `OFF_IRQ_MASK:     rdata_r <= {31'h0000_0000, enable_r};
        `OFF_OUT_SELECT:   rdata_r <= {31'h0000_0000, spi_sel_r};
        default:           rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================
  // outputs, each straight from its own flop
  assign o_awready    = awready_r;
  assign o_wready     = wready_r;
  assign o_bvalid     = bvalid_r;
  assign o_bresp      = bresp_r;
  assign o_arready    = arready_r;
  assign o_rvalid     = rvalid_r;
  assign o_rdata      = rdata_r;
  assign o_rresp      = rresp_r;
  // one driver for the whole struct, match in the upper bit
  assign o_tmr        = {match_r, spi_clk_r};
  assign o_irq        = irq_r;

endmodule // period_match_timer

// File: hdl/period_match_timer_defines.svh
`ifndef PERIOD_MATCH_TIMER_DEFINES_SVH
`define PERIOD_MATCH_TIMER_DEFINES_SVH

// ==========================================
// register byte offsets
`define OFF_COUNT_VALUE     8'h00
`define OFF_PERIOD_VALUE    8'h04
`define OFF_CONTROL         8'h08
`define OFF_IRQ_STATUS      8'h0C
`define OFF_IRQ_MASK        8'h10
`define OFF_OUT_SELECT      8'h14

// ==========================================
// control field positions
`define CTL_IN_DIV_LSB      0
`define CTL_RUN_BIT         2
`define CTL_OUT_DIV_LSB     3

// ==========================================
// reset values
`define RST_COUNT_VALUE     8'h00
`define RST_PERIOD_VALUE    8'hFF
`define RST_CONTROL         7'h00

// ==========================================
// prescaler terminal counts
`define PRE_TC_DIV1         4'h0
`define PRE_TC_DIV4         4'h3
`define PRE_TC_DIV16        4'hF

// ==========================================
// instruction clock divide
`define ICLK_DIV_TC         2'h3

// ==========================================
// axi responses
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// File: hdl/period_match_timer_pkg.sv
package period_match_timer_pkg;

  // ==========================================
  // control register layout
  typedef struct packed {
    logic [3:0] out_div;  // output_divider_select
    logic       run;      // counter_run
    logic [1:0] in_div;   // input_divider_select
  } control_t;

  // ==========================================
  // timer outputs to neighbours
  typedef struct packed {
    logic match;          // unscaled match pulse
    logic spi_clk;        // shift clock toggle
  } timer_out_t;

  // ==========================================
  // write channel state
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;

endpackage

// File: tb/period_match_timer_chk.sv
`timescale 1ns/100ps
// ==========================================
// port checker for the period match timer
module period_match_timer_chk (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // watched inputs
  input wire logic        i_sleep, i_awvalid, i_wvalid, i_arvalid, i_bready, i_rready,
  // watched outputs
  input wire logic        o_awready, o_wready, o_arready, o_bvalid, o_rvalid, o_irq,
  input wire logic [1:0]  o_bresp,
  input wire logic [31:0] o_rdata,
  input wire period_match_timer_pkg::timer_out_t o_tmr
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // answers stand until taken
  property p_bhold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
  property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  // answer latency and refusal
  property p_rans; i_arvalid && o_arready |=> o_rvalid; endproperty
  property p_rref; o_rvalid |-> !o_arready; endproperty
  property p_wref; o_bvalid |-> !o_awready && !o_wready; endproperty
  property p_bans; i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid; endproperty
  // match is a lone pulse, ticks are four clocks apart
  property p_match; o_tmr.match |=> !o_tmr.match [*3]; endproperty
  // sleep stops the count, so no match once synchronised
  property p_sleep; i_sleep [*6] |-> !o_tmr.match; endproperty
  // state just after reset
  property p_rst; $fell(i_rst) |-> o_awready && o_arready && !o_bvalid && !o_irq; endproperty
  a_bhold: assert property (p_bhold)
    else $error("write answer not held");
  a_rhold: assert property (p_rhold)
    else $error("read answer not held");
  a_rans: assert property (p_rans)
    else $error("read answer late");
  a_rref: assert property (p_rref)
    else $error("read taken while answer pending");
  a_wref: assert property (p_wref)
    else $error("write taken while answer pending");
  a_bans: assert property (p_bans)
    else $error("write answer late");
  a_match: assert property (p_match)
    else $error("match pulse too long");
  a_sleep: assert property (p_sleep)
    else $error("match during sleep");
  a_rst: assert property (p_rst)
    else $error("wrong state after reset");
  c_match: cover property (o_tmr.match);
  c_irq: cover property ($rose(o_irq));
  c_err: cover property (o_bvalid && o_bresp == 2'h2);
endmodule // period_match_timer_chk

// File: tb/period_match_timer_test.sv
`timescale 1ns/100ps
`include "period_match_timer_defines.svh"
// ==========================================
// register level bench
module period_match_timer_test;
  logic        i_clk = 0, i_rst = 1, i_sleep = 0;
  logic [7:0]  i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0, rd, o_rdata;
  logic [3:0]  i_wstrb = 0, strb = 4'h1;
  logic        i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, old;
  logic [1:0]  o_bresp, o_rresp, rsp;
  period_match_timer_pkg::timer_out_t o_tmr;
  int          fails = 0, check_count = 0, mcnt = 0, late = 0, m0, n, i, g;
  always #2.5 i_clk = ~i_clk;
  // counts every unscaled match
  always @(posedge i_clk) if (o_tmr.match === 1'b1) mcnt <= mcnt + 1;
  period_match_timer dut (.i_clk(i_clk), .i_rst(i_rst), .i_sleep(i_sleep),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_tmr(o_tmr), .o_irq(o_irq));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, e, s);
    end
  endtask
  // axi lite write, both channels offered together; late holds bready back
  task bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_awaddr <= a; i_wdata <= d; i_wstrb <= strb;
    i_awvalid <= 1'b1; i_wvalid <= 1'b1; i_bready <= (late == 0);
    for (n = 0; n < 100; n++) begin
      @(posedge i_clk);
      if (o_awready === 1'b1) i_awvalid <= 1'b0;
      if (o_wready === 1'b1) i_wvalid <= 1'b0;
      if (o_bvalid === 1'b1 && i_bready === 1'b1) break;
      if (n + 1 == late) i_bready <= 1'b1;
    end
    rsp = o_bresp; i_bready <= 1'b0;
    if (n == 100) fails++;
  endtask
  // axi lite read
  task bus_rd(input logic [7:0] a);
    @(posedge i_clk);
    i_araddr <= a; i_arvalid <= 1'b1; i_rready <= (late == 0);
    for (n = 0; n < 100; n++) begin
      @(posedge i_clk);
      if (o_arready === 1'b1) i_arvalid <= 1'b0;
      if (o_rvalid === 1'b1 && i_rready === 1'b1) break;
      if (n + 1 == late) i_rready <= 1'b1;
    end
    rd = o_rdata; rsp = o_rresp; i_rready <= 1'b0;
    if (n == 100) fails++;
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus_rd(a);
    chk(nm, e, rd);
  endtask
  // waits for a match; gap then counts clocks to the next one
  task wmatch;
    for (n = 0; n < 3000; n++) begin
      @(posedge i_clk);
      if (o_tmr.match === 1'b1) break;
    end
  endtask
  task gap;
    wmatch();
    for (g = 1; g < 3000; g++) begin
      @(posedge i_clk);
      if (o_tmr.match === 1'b1) break;
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    rchk("count", `OFF_COUNT_VALUE, 32'h0000_0000);
    rchk("period", `OFF_PERIOD_VALUE, 32'h0000_00FF);
    rchk("control", `OFF_CONTROL, 32'h0000_0000);
    rchk("status", `OFF_IRQ_STATUS, 32'h0000_0000);
    bus_rd(8'h18);
    chk("bad rresp", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
    bus_wr(8'h18, 32'h0000_0001);
    chk("bad bresp", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
    late = 4;
    bus_wr(`OFF_COUNT_VALUE, 32'h0000_005A);
    bus_wr(`OFF_CONTROL, 32'h0000_0000);
    rchk("count kept", `OFF_COUNT_VALUE, 32'h0000_005A);
    late = 0;
    strb = 4'h0;
    bus_wr(`OFF_PERIOD_VALUE, 32'h0000_0011);
    strb = 4'h1;
    rchk("no strobe", `OFF_PERIOD_VALUE, 32'h0000_00FF);
    $display("test registers done");
    // period 3 gives five counting ticks per cycle
    bus_wr(`OFF_PERIOD_VALUE, 32'h0000_0003);
    for (i = 0; i < 4; i++) begin
      bus_wr(`OFF_CONTROL, 32'h0000_0004 | i);
      gap();
      chk("gap", 20 * (i == 0 ? 1 : (i == 1 ? 4 : 16)), g);
    end
    $display("test prescaler done");
    // every postscale ratio, counted from cleared scalers
    bus_wr(`OFF_IRQ_MASK, 32'h0000_0001);
    for (i = 0; i < 16; i++) begin
      bus_wr(`OFF_CONTROL, i << 3);
      bus_wr(`OFF_COUNT_VALUE, 32'h0000_0000);
      bus_wr(`OFF_IRQ_STATUS, 32'h0000_0001);
      m0 = mcnt;
      bus_wr(`OFF_CONTROL, (i << 3) | 4);
      for (n = 0; n < 3000; n++) begin
        @(posedge i_clk);
        if (o_irq === 1'b1) break;
      end
      chk("matches", i + 1, mcnt - m0);
    end
    bus_wr(`OFF_CONTROL, 32'h0000_0000);
    rchk("flag held", `OFF_IRQ_STATUS, 32'h0000_0001);
    bus_wr(`OFF_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge i_clk);
    chk("masked irq", 32'h0, {31'h0, o_irq});
    bus_wr(`OFF_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge i_clk);
    chk("irq", 32'h1, {31'h0, o_irq});
    bus_wr(`OFF_IRQ_STATUS, 32'h0000_0001);
    repeat (2) @(posedge i_clk);
    chk("cleared irq", 32'h0, {31'h0, o_irq});
    $display("test postscaler done");
    bus_wr(`OFF_COUNT_VALUE, 32'h0000_0002);
    repeat (40) @(posedge i_clk);
    rchk("stopped", `OFF_COUNT_VALUE, 32'h0000_0002);
    bus_wr(`OFF_CONTROL, 32'h0000_0004);
    i_sleep <= 1'b1;
    repeat (10) @(posedge i_clk);
    bus_rd(`OFF_COUNT_VALUE);
    m0 = rd;
    repeat (100) @(posedge i_clk);
    rchk("asleep", `OFF_COUNT_VALUE, m0);
    rchk("asleep period", `OFF_PERIOD_VALUE, 32'h0000_0003);
    i_sleep <= 1'b0;
    $display("test run and sleep done");
    for (i = 1; i >= 0; i--) begin
      bus_wr(`OFF_OUT_SELECT, i);
      old = o_tmr.spi_clk;
      wmatch();
      repeat (2) @(posedge i_clk);
      chk("spi clock", {31'h0, old ^ i[0]}, {31'h0, o_tmr.spi_clk});
    end
    $display("test shift clock done");
    report_and_stop();
  end
endmodule // period_match_timer_test
bind period_match_timer period_match_timer_chk chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_sleep(i_sleep), .i_awvalid(i_awvalid), .i_wvalid(i_wvalid), .i_arvalid(i_arvalid),
  .i_bready(i_bready), .i_rready(i_rready), .o_awready(o_awready), .o_wready(o_wready),
  .o_arready(o_arready), .o_bvalid(o_bvalid), .o_rvalid(o_rvalid), .o_irq(o_irq),
  .o_bresp(o_bresp), .o_rdata(o_rdata), .o_tmr(o_tmr));
